// [core/i2cmsr_pkg.sv]
package i2cmsr_pkg;
  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_STATUS   = 8'h13;
  localparam logic [7:0] IDX_CONTROL2 = 8'h14;
  localparam logic [7:0] IDX_CONTROL1 = 8'h15;
  localparam logic [7:0] IDX_BUFFER   = 8'h16;
  localparam logic [7:0] IDX_ADDRRATE = 8'h17;
  localparam logic [7:0] IDX_FLAGS    = 8'h18;
  // ==========================================================
  // status field positions
  localparam int ST_SAMPLE_PHASE = 7;
  localparam int ST_CLOCK_EDGE   = 6;
  localparam int ST_DATA_ADDR    = 5;
  localparam int ST_STOP         = 4;
  localparam int ST_START        = 3;
  localparam int ST_READ_WRITE   = 2;
  localparam int ST_ADDR_UPDATE  = 1;
  localparam int ST_BUFFER_FULL  = 0;
  // ==========================================================
  // control two field positions
  localparam int C2_START_EN   = 0;
  localparam int C2_RSTART_EN  = 1;
  localparam int C2_STOP_EN    = 2;
  localparam int C2_RECEIVE_EN = 3;
  localparam int C2_ACK_EN     = 4;
  localparam int C2_LOW_BITS   = 5;
  // ==========================================================
  // control one field positions
  localparam int C1_I2C_MODE   = 0;
  localparam int C1_SLAVE_MODE = 1;
  localparam int C1_POLARITY   = 4;
  localparam int C1_PORT_EN    = 5;
  // ==========================================================
  // flags field positions
  localparam int FL_BUS_COLL   = 0;
  localparam int FL_WRITE_COLL = 1;
  localparam int FL_OVERFLOW   = 2;
  localparam int FL_PORT_INT   = 3;
  // ==========================================================
  // reset values and misc
  localparam logic [7:0] RST_REG      = 8'h00;
  localparam logic [2:0] BITS_PER_BYTE = 3'h7;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// [core/i2cmsr_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module i2cmsr_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;

  // ==========================================================
  // two-flop synchroniser, idle level of the bus is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1   <= 1'b1;
      sync_out <= 1'b1;
    end else if (ce) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// [core/i2cmsr_rategen.sv]
`timescale 1ns/10ps
`default_nettype none
module i2cmsr_rategen (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic       stop,
  input  wire logic [6:0] reload,
  output logic            expire
);
  logic [6:0] count;
  logic       running;

  // ==========================================================
  // reload counter: expires every reload+1 cycles while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count   <= 7'h00;
      running <= 1'b0;
    end else if (ce) begin
      if (stop) begin
        running <= 1'b0;
      end else if (load) begin
        count   <= reload;
        running <= 1'b1;
      end else if (running) begin
        count <= (count == 7'h00) ? reload : count - 7'h01;
      end
    end
  end

  // stop must not gate expire: the sequencer derives stop from expire
  assign expire = ce && running && !load && (count == 7'h00);
endmodule
`default_nettype wire

// [core/i2cmsr_top.sv]
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module i2cmsr_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        transmit_busy,
  input  wire logic        transmit_full,
  input  wire logic        slave_read_write,
  input  wire logic        address_update_needed,
  output logic             spi_sample_at_end,
  output logic             spi_transmit_rising,
  output logic             slew_control_on,
  output logic             port_idle,
  output logic             port_interrupt_flag,
  output logic             bus_collision_flag
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_START_CHECK, ST_START_HOLD, ST_RX_LOW, ST_RX_HIGH
  } i2cmsr_state_e;

  i2cmsr_state_e state;
  logic [7:0]    status_hi;
  logic [5:0]    control_two;
  logic [7:0]    control_one;
  logic [7:0]    data_buffer;
  logic [7:0]    address_or_rate_reg;
  logic [7:0]    shift_register;
  logic [2:0]    bit_count;
  logic          data_address;
  logic          stop_seen;
  logic          start_seen;
  logic          buffer_full;
  logic          write_collision_flag;
  logic          receive_overflow_flag;
  logic          scl_drive;
  logic          sda_drive;
  logic          scl_s;
  logic          sda_s;
  logic          scl_d;
  logic          sda_d;
  logic          brg_load;
  logic          brg_stop;
  logic          brg_expire;
  logic          aw_held;
  logic          w_held;
  logic [31:0]   aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          wr_fire;
  logic          rd_fire;
  logic          wr_byte;
  logic          port_enable;
  logic          busy;
  logic          byte_done;
  logic [7:0]    status_read;
  logic [7:0]    flags_read;

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] idx);
    hit = (addr[31:10] == 22'h0) && (addr[9:2] == idx);
  endfunction

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hit(addr, i2cmsr_pkg::IDX_STATUS)   || hit(addr, i2cmsr_pkg::IDX_CONTROL2) ||
             hit(addr, i2cmsr_pkg::IDX_CONTROL1) || hit(addr, i2cmsr_pkg::IDX_BUFFER)   ||
             hit(addr, i2cmsr_pkg::IDX_ADDRRATE) || hit(addr, i2cmsr_pkg::IDX_FLAGS);
  endfunction

  // ==========================================================
  // pin synchronisers and rate generator
  i2cmsr_sync u_scl_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in (scl_in),
    .sync_out (scl_s)
  );

  i2cmsr_sync u_sda_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in (sda_in),
    .sync_out (sda_s)
  );

  i2cmsr_rategen u_rategen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .load    (brg_load),
    .stop    (brg_stop),
    .reload  (address_or_rate_reg[6:0]),
    .expire  (brg_expire)
  );

  // ==========================================================
  // axi4-lite write channel: address and data in either order
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
  assign wr_fire       = ce && aw_held && w_held && !s_axi_bvalid;
  assign wr_byte       = wr_fire && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 32'h00000000;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= i2cmsr_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? i2cmsr_pkg::RESP_OKAY : i2cmsr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign rd_fire       = ce && s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= i2cmsr_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? i2cmsr_pkg::RESP_OKAY : i2cmsr_pkg::RESP_SLVERR;
        s_axi_rdata  <= 32'h00000000;
        if (hit(s_axi_araddr, i2cmsr_pkg::IDX_STATUS)) begin
          s_axi_rdata[7:0] <= status_read;
        end else if (hit(s_axi_araddr, i2cmsr_pkg::IDX_CONTROL2)) begin
          s_axi_rdata[5:0] <= control_two;
        end else if (hit(s_axi_araddr, i2cmsr_pkg::IDX_CONTROL1)) begin
          s_axi_rdata[7:0] <= control_one;
        end else if (hit(s_axi_araddr, i2cmsr_pkg::IDX_BUFFER)) begin
          s_axi_rdata[7:0] <= data_buffer;
        end else if (hit(s_axi_araddr, i2cmsr_pkg::IDX_ADDRRATE)) begin
          s_axi_rdata[7:0] <= address_or_rate_reg;
        end else if (hit(s_axi_araddr, i2cmsr_pkg::IDX_FLAGS)) begin
          s_axi_rdata[7:0] <= flags_read;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status and flag views
  assign port_enable = control_one[i2cmsr_pkg::C1_PORT_EN];
  assign busy = (state != ST_IDLE) || transmit_busy;

  always_comb begin
    status_read = status_hi;
    status_read[i2cmsr_pkg::ST_DATA_ADDR] = data_address;
    status_read[i2cmsr_pkg::ST_STOP]      = stop_seen;
    status_read[i2cmsr_pkg::ST_START]     = start_seen;
    status_read[i2cmsr_pkg::ST_READ_WRITE] =
      control_one[i2cmsr_pkg::C1_SLAVE_MODE] ? slave_read_write : transmit_busy;
    status_read[i2cmsr_pkg::ST_ADDR_UPDATE] = address_update_needed;
    status_read[i2cmsr_pkg::ST_BUFFER_FULL] = buffer_full || transmit_full;
    flags_read = 8'h00;
    flags_read[i2cmsr_pkg::FL_BUS_COLL]   = bus_collision_flag;
    flags_read[i2cmsr_pkg::FL_WRITE_COLL] = write_collision_flag;
    flags_read[i2cmsr_pkg::FL_OVERFLOW]   = receive_overflow_flag;
    flags_read[i2cmsr_pkg::FL_PORT_INT]   = port_interrupt_flag;
  end

  assign spi_sample_at_end   = status_hi[i2cmsr_pkg::ST_SAMPLE_PHASE];
  assign slew_control_on     = control_one[i2cmsr_pkg::C1_I2C_MODE] &&
                               !status_hi[i2cmsr_pkg::ST_SAMPLE_PHASE];
  assign spi_transmit_rising = status_hi[i2cmsr_pkg::ST_CLOCK_EDGE] ^
                               control_one[i2cmsr_pkg::C1_POLARITY];
  assign port_idle = !(transmit_busy || (|control_two[4:0]));

  // ==========================================================
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_hi           <= i2cmsr_pkg::RST_REG;
      control_one         <= i2cmsr_pkg::RST_REG;
      address_or_rate_reg <= i2cmsr_pkg::RST_REG;
    end else if (ce && wr_byte) begin
      if (hit(aw_addr, i2cmsr_pkg::IDX_STATUS)) begin
        status_hi <= {w_data[7:6], 6'h00};
      end
      if (hit(aw_addr, i2cmsr_pkg::IDX_CONTROL1)) begin
        control_one <= w_data[7:0];
      end
      if (hit(aw_addr, i2cmsr_pkg::IDX_ADDRRATE)) begin
        address_or_rate_reg <= w_data[7:0];
      end
    end
  end

  // ==========================================================
  // bus condition detector on synchronised lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end else if (ce) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (!port_enable) begin
        start_seen <= 1'b0;
        stop_seen  <= 1'b0;
      end else if (scl_s && scl_d && sda_d && !sda_s) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end else if (scl_s && scl_d && !sda_d && sda_s) begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
      end
    end
  end

  // ==========================================================
  // master sequencer: start condition and byte reception
  assign byte_done = port_enable && (state == ST_RX_HIGH) && brg_expire &&
                     (bit_count == i2cmsr_pkg::BITS_PER_BYTE);

  always_comb begin
    brg_load = 1'b0;
    brg_stop = 1'b0;
    if (!port_enable) begin
      brg_stop = 1'b1;
    end else if (state == ST_IDLE && wr_byte && hit(aw_addr, i2cmsr_pkg::IDX_CONTROL2)) begin
      brg_load = (w_data[i2cmsr_pkg::C2_START_EN] && scl_s && sda_s) ||
                 (w_data[i2cmsr_pkg::C2_RECEIVE_EN] && !(|control_two[4:0]) && !busy);
    end else if (state == ST_START_CHECK && (!scl_s || !sda_s)) begin
      brg_stop = 1'b1;
    end else if ((state == ST_START_HOLD && brg_expire) || byte_done) begin
      brg_stop = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state              <= ST_IDLE;
      control_two        <= 6'h00;
      scl_drive          <= 1'b0;
      sda_drive          <= 1'b0;
      bit_count          <= 3'h0;
      shift_register     <= 8'h00;
      bus_collision_flag <= 1'b0;
    end else if (ce) begin
      if (wr_byte && hit(aw_addr, i2cmsr_pkg::IDX_FLAGS) && w_data[i2cmsr_pkg::FL_BUS_COLL]) begin
        bus_collision_flag <= 1'b0;
      end
      if (!port_enable) begin
        state       <= ST_IDLE;
        control_two <= 6'h00;
        scl_drive   <= 1'b0;
        sda_drive   <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (wr_byte && hit(aw_addr, i2cmsr_pkg::IDX_CONTROL2)) begin
              control_two[5] <= w_data[i2cmsr_pkg::C2_LOW_BITS];
              if (w_data[i2cmsr_pkg::C2_START_EN]) begin
                if (scl_s && sda_s) begin
                  control_two[i2cmsr_pkg::C2_START_EN] <= 1'b1;
                  sda_drive <= 1'b0;
                  state     <= ST_START_CHECK;
                end else begin
                  bus_collision_flag <= 1'b1;
                end
              end else if (w_data[i2cmsr_pkg::C2_RECEIVE_EN]) begin
                if (!(|control_two[4:0]) && !busy) begin
                  control_two[i2cmsr_pkg::C2_RECEIVE_EN] <= 1'b1;
                  scl_drive <= 1'b1;
                  sda_drive <= 1'b0;
                  bit_count <= 3'h0;
                  state     <= ST_RX_LOW;
                end
              end else begin
                control_two[4:0] <= w_data[4:0];
              end
            end
          end
          ST_START_CHECK: begin
            if (!scl_s || !sda_s) begin
              bus_collision_flag <= 1'b1;
              control_two[i2cmsr_pkg::C2_START_EN] <= 1'b0;
              state <= ST_IDLE;
            end else if (brg_expire) begin
              sda_drive <= 1'b1;
              state     <= ST_START_HOLD;
            end
          end
          ST_START_HOLD: begin
            if (brg_expire) begin
              control_two[i2cmsr_pkg::C2_START_EN] <= 1'b0;
              state <= ST_IDLE;
            end
          end
          ST_RX_LOW: begin
            if (brg_expire) begin
              scl_drive <= 1'b0;
              state     <= ST_RX_HIGH;
            end
          end
          ST_RX_HIGH: begin
            if (brg_expire) begin
              scl_drive      <= 1'b1;
              shift_register <= {shift_register[6:0], sda_s};
              bit_count      <= bit_count + 3'h1;
              if (bit_count == i2cmsr_pkg::BITS_PER_BYTE) begin
                control_two[i2cmsr_pkg::C2_RECEIVE_EN] <= 1'b0;
                state <= ST_IDLE;
              end else begin
                state <= ST_RX_LOW;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // buffer, full flag, overflow, write collision, interrupt flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_buffer           <= 8'h00;
      buffer_full           <= 1'b0;
      data_address          <= 1'b0;
      write_collision_flag  <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_interrupt_flag   <= 1'b0;
    end else if (ce) begin
      if (wr_byte && hit(aw_addr, i2cmsr_pkg::IDX_FLAGS)) begin
        if (w_data[i2cmsr_pkg::FL_WRITE_COLL]) write_collision_flag <= 1'b0;
        if (w_data[i2cmsr_pkg::FL_OVERFLOW]) receive_overflow_flag <= 1'b0;
        if (w_data[i2cmsr_pkg::FL_PORT_INT]) port_interrupt_flag <= 1'b0;
      end
      if (rd_fire && hit(s_axi_araddr, i2cmsr_pkg::IDX_BUFFER)) begin
        buffer_full <= 1'b0;
      end
      if (wr_byte && hit(aw_addr, i2cmsr_pkg::IDX_BUFFER)) begin
        if (state != ST_IDLE) begin
          write_collision_flag <= 1'b1;
        end else begin
          data_buffer <= w_data[7:0];
        end
      end
      if (state == ST_START_HOLD && brg_expire) begin
        data_address <= 1'b0;
      end
      if (byte_done) begin
        port_interrupt_flag <= 1'b1;
        data_address        <= 1'b1;
        if (buffer_full) begin
          receive_overflow_flag <= 1'b1;
        end else begin
          data_buffer <= {shift_register[6:0], sda_s};
          buffer_full <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // open-drain pins: drive low with enable low
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = !scl_drive;
  assign sda_oe_n = !sda_drive;
endmodule
`default_nettype wire

// [test/i2cmsr_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module i2cmsr_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic transmit_busy,
  input wire logic port_idle,
  input wire logic slew_control_on,
  input wire logic spi_sample_at_end,
  input wire logic port_interrupt_flag,
  input wire logic bus_collision_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // pin and flag relations
  property p_slew; slew_control_on |-> !spi_sample_at_end; endproperty
  a_slew: assert property (p_slew) else $error("slew with late sample");
  property p_idle; transmit_busy |-> !port_idle; endproperty
  a_idle: assert property (p_idle) else $error("idle while busy");
  property p_go; $fell(sda_oe_n) |-> $past(scl_in) && $past(sda_in); endproperty
  a_go: assert property (p_go) else $error("sda pulled with a line low");
  property p_sda; !sda_oe_n |-> scl_oe_n; endproperty
  a_sda: assert property (p_sda) else $error("sda low with scl low");
  property p_hold; $fell(sda_oe_n) |=> !sda_oe_n [*4]; endproperty
  a_hold: assert property (p_hold) else $error("sda not held");
  property p_coll; $rose(bus_collision_flag) |-> ##[0:2] (sda_oe_n && scl_oe_n); endproperty
  a_coll: assert property (p_coll) else $error("lines kept after collision");
  property p_tick; $changed(scl_oe_n) |=> $stable(scl_oe_n) [*4]; endproperty
  a_tick: assert property (p_tick) else $error("scl toggles too fast");
  property p_done; $rose(port_interrupt_flag) |-> !scl_oe_n [*5]; endproperty
  a_done: assert property (p_done) else $error("scl not held after byte");
  c_done: cover property ($rose(port_interrupt_flag));
  c_coll: cover property ($rose(bus_collision_flag));
  c_go: cover property ($fell(sda_oe_n));
endmodule
bind i2cmsr_top i2cmsr_chk chk_u (.aclk, .aresetn, .scl_in, .sda_in, .scl_oe_n, .sda_oe_n,
  .transmit_busy, .port_idle, .slew_control_on, .spi_sample_at_end, .port_interrupt_flag,
  .bus_collision_flag);
`default_nettype wire

// [test/i2cmsr_slave.sv]
`timescale 1ns/10ps
`default_nettype none
module i2cmsr_slave (
  input  wire logic       scl_oe_n,
  input  wire logic       sda_oe_n,
  input  wire logic       hold,
  input  wire logic       txe,
  input  wire logic [7:0] txb,
  output logic            scl,
  output logic            sda
);
  int   n = 0;
  logic q = 1'h1;
  // ==========================================================
  // open-drain lines with pull-ups; bits change while scl is low
  assign scl = scl_oe_n & ~hold;
  assign sda = sda_oe_n & (q | ~txe);
  always @(posedge txe) begin
    n = 0;
    // first bit only while scl is low, so no false start or stop
    q = scl ? 1'h1 : txb[7];
  end
  always @(posedge scl) if (txe) n = n + 1;
  always @(negedge scl) q = (txe && n < 8) ? txb[7 - n] : 1'h1;
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected %0t: %h not %h", $time, a, b); end end
module testbench;
  localparam logic [31:0] A_ST = 32'h4C, A_C2 = 32'h50, A_C1 = 32'h54;
  localparam logic [31:0] A_BU = 32'h58, A_AR = 32'h5C, A_FL = 32'h60;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic        busy = 0, full = 0, srw = 0, aun = 0, hold = 0, txe = 0;
  logic [31:0] aw = 0, wd = 0, ar = 0, rdat;
  logic        awr, wrdy, bv, arr, rv, scl_oe_n, sda_oe_n, sample_phase, rise, slw, idl, pint, bcol;
  logic        sclo, sdao;
  logic [1:0]  br, rr;
  logic [7:0]  txb = 0, b0;
  logic [34:0] q[$], e;
  wire         scl, sda;
  int          err_count = 0, checked = 0;
  i2cmsr_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .scl_in(scl), .scl_out(sclo),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sdao), .sda_oe_n(sda_oe_n),
    .transmit_busy(busy), .transmit_full(full), .slave_read_write(srw),
    .address_update_needed(aun), .spi_sample_at_end(sample_phase), .spi_transmit_rising(rise),
    .slew_control_on(slw), .port_idle(idl), .port_interrupt_flag(pint),
    .bus_collision_flag(bcol));
  i2cmsr_slave slave_u (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .hold(hold), .txe(txe),
    .txb(txb), .scl(scl), .sda(sda));
  initial forever #2.5 aclk = ~aclk;
  // ==========================================================
  // answer checker: oldest note against each response
  always @(posedge aclk) if ((bv && bre) || (rv && rre)) begin
    e = q.pop_front();
    `CHK({bv ? br : rr, e[34] ? 32'h0 : rdat}, e[33:0])
  end
  // ==========================================================
  // bus tasks
  task automatic ax(input logic w, input logic [31:0] a, d, input logic [34:0] x);
    @(posedge aclk);
    q.push_back(x);
    aw <= a;
    ar <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    bre <= w;
    arv <= ~w;
    rre <= ~w;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
      if (arr) arv <= 0;
    end while (!((bv && bre) || (rv && rre)));
    bre <= 0;
    rre <= 0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    ax(1'h1, a, d, {1'h1, i2cmsr_pkg::RESP_OKAY, 32'h0});
  endtask
  task automatic rd(input logic [31:0] a, d);
    ax(1'h0, a, 32'h0, {1'h0, i2cmsr_pkg::RESP_OKAY, d});
  endtask
  task automatic wrap_up;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h19B5));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(A_ST, 32'h0);
    ax(1'h1, 32'h100, 32'h1, {1'h1, i2cmsr_pkg::RESP_SLVERR, 32'h0});
    ax(1'h0, 32'h100, 32'h0, {1'h1, i2cmsr_pkg::RESP_SLVERR, 32'h0});
    for (int i = 0; i < 16; i++) begin
      wr(A_C1, {27'h0, i[2], 3'h0, i[3]});
      wr(A_ST, {24'h0, i[1:0], 6'h0});
      `CHK(sample_phase, i[1])
      `CHK(rise, i[0] ^ i[2])
      `CHK(slw, i[3] & ~i[1])
    end
    wr(A_ST, 32'h0);
    for (int k = 0; k < 4; k++) begin
      logic [4:0] v;
      v = 5'($urandom);
      {busy, full, srw, aun} <= v[4:1];
      wr(A_C1, {30'h0, v[0], 1'h1});
      rd(A_ST, {29'h0, v[0] ? v[2] : v[4], v[1], v[3]});
      `CHK(idl, ~v[4])
    end
    {busy, full, srw, aun} <= 4'h0;
    wr(A_C1, 32'h21);
    wr(A_AR, 32'h7);
    wr(A_C2, 32'h1);
    wr(A_BU, 32'hA5);
    wr(A_C2, 32'h8);
    repeat (40) @(posedge aclk);
    `CHK(sda_oe_n, 1'h0)
    `CHK({sclo, sdao}, 2'h0)
    rd(A_C2, 32'h0);
    rd(A_ST, 32'h8);
    rd(A_FL, 32'h2);
    rd(A_BU, 32'h0);
    wr(A_FL, 32'hF);
    wr(A_C1, 32'h1);
    rd(A_ST, 32'h0);
    wr(A_C1, 32'h21);
    for (int d = 0; d < 2; d++) begin
      hold <= (d == 0);
      wr(A_C2, 32'h1);
      hold <= 1;
      repeat (9) @(posedge aclk);
      `CHK(bcol, 1'h1)
      rd(A_C2, 32'h0);
      hold <= 0;
      wr(A_FL, 32'hF);
    end
    for (int r = 0; r < 2; r++) begin
      logic [7:0] b;
      b = 8'($urandom);
      if (r == 0) b0 = b;
      txb <= b;
      txe <= 0;
      repeat (2) @(posedge aclk);
      txe <= 1;
      wr(A_C2, 32'h8);
      if (r == 0) wr(A_BU, 32'h5A);
      for (int i = 0; i < 400 && pint !== 1'h1; i++) @(posedge aclk);
      `CHK(pint, 1'h1)
      `CHK(scl_oe_n, 1'h0)
      rd(A_C2, 32'h0);
      rd(A_ST, 32'h21);
      rd(A_FL, r ? 32'hC : 32'hA);
      wr(A_FL, 32'hF);
    end
    rd(A_BU, {24'h0, b0});
    rd(A_ST, 32'h20);
    busy <= 1;
    wr(A_C2, 32'h8);
    repeat (200) @(posedge aclk);
    `CHK(pint, 1'h0)
    wrap_up();
  end
  // about ten times the expected run length
  initial begin
    #40000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
